// >>> hdl/spi_flash_cfg.svh
// constants of the serial flash startup controller
`ifndef SPI_FLASH_CFG_SVH
`define SPI_FLASH_CFG_SVH

// flash opcodes
`define SF_CMD_WRITE_ENABLE  8'h06
`define SF_CMD_WR_EXT_ADDR   8'hc5
`define SF_CMD_READ_STATUS   8'h05
`define SF_CMD_FAST_READ     8'h0b
`define SF_CMD_PAGE_PROGRAM  8'h02
`define SF_CMD_SECTOR_ERASE  8'hd8

// request address layout
`define SF_ERASE_BIT         25
`define SF_UPPER_BIT         24

// status bit that shows a program or erase in progress
`define SF_WIP_BIT           0

// frame lengths in serial clock cycles
`define SF_HANDOVER_CLKS     7'h05
`define SF_DUMMY_CLKS        7'h08
`define SF_CMD_BITS          7'h08
`define SF_ADDR_CMD_BITS     7'h20
`define SF_PROG_BITS         7'h40
`define SF_WORD_BITS         7'h20
`define SF_EXT_BITS          7'h10
`define SF_STATUS_BITS       7'h08

// link cycles counted down after select rises; select stays high one cycle longer
`define SF_GAP_CYCLES        2'h3

// reset levels of the flash pins
`define SF_SELECT_N_RESET    1'b1
`define SF_DATA_OUT_RESET    1'b0
`define SF_STRAP_HIGH        1'b1

`endif

// >>> hdl/spi_flash_pkg.sv
// types shared by the serial flash startup controller
package spi_flash_pkg;

  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_ERASE
  } op_e;

  typedef enum logic [3:0] {
    L_WAIT_START,
    L_HANDOVER,
    L_IDLE,
    L_EXT_WREN,
    L_EXT_SET,
    L_OP_START,
    L_OP_WREN,
    L_READ,
    L_POLL,
    L_POLL_CHECK,
    L_DONE
  } link_state_e;

endpackage

// >>> hdl/bit_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module bit_sync (
  // clock of the receiving domain
  input  wire logic i_clk,
  // asynchronous level in, synchronised level out
  input  wire logic i_d,
  output logic      o_q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_s;

  sync_s r;
  sync_s next_r;

  // first stage feeds only the second
  always_comb begin
    next_r    = r;
    next_r.s1 = i_d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge i_clk) begin
    r <= next_r;
  end

  assign o_q = r.s2;

endmodule

`default_nettype wire

// >>> hdl/spi_flash_startup_ctrl.sv
// serial flash controller with one-time clock handover burst
//
// Functional notes
// - core request logic runs on one core clock
// - reset input is active low
// - serial clock toggles only while selected
// - five serial clocks once startup done is seen after reset exit
// - handover needs three clocks, five give margin
// - handover burst runs once per reset
// - no serial clock before startup done
// - data out low unless shifting while selected
// - data in sampled only while selected
// - write protect held high
// - hold line held high
// - select active low, high after reset
// - select falling edge precedes any command
// - top address bit flags sector erase on a write, a read ignores it
// - only erase, program and fast read
// - extended address follows address bit 24
// - one access at a time, four bytes
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_cfg.svh"

module spi_flash_startup_ctrl (
  // core clock domain
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  // link clock domain
  input  wire logic        I_LINK_CLK,
  // request port
  input  wire logic        I_REQ_VALID,
  input  wire logic        I_REQ_WRITE,
  input  wire logic [25:0] I_REQ_ADDR,
  input  wire logic [31:0] I_REQ_WDATA,
  output logic             O_REQ_READY,
  // answer port
  output logic             O_RSP_VALID,
  output logic [31:0]      O_RSP_RDATA,
  // configuration status
  input  wire logic        I_STARTUP_DONE,
  // flash pins
  output logic             O_FLASH_CLOCK_PIN,
  output logic             O_FLASH_SELECT_N,
  output logic             O_FLASH_SERIAL_OUT,
  input  wire logic        I_FLASH_SERIAL_IN,
  output logic             O_FLASH_WRITE_PROTECT_N,
  output logic             O_FLASH_PAUSE_N
);

  // core side state
  typedef struct packed {
    logic                busy;
    logic                req_tgl;
    logic                ack_seen;
    spi_flash_pkg::op_e  op;
    logic [24:0]         addr;
    logic [31:0]         wdata;
    logic                rsp;
    logic [31:0]         rdata;
  } core_s;

  // link side state
  typedef struct packed {
    spi_flash_pkg::link_state_e st;
    logic                req_seen;
    logic                ack_tgl;
    logic                ext_upper;
    logic                want_upper;
    logic                frame;
    logic                ph;
    logic                sel_n;
    logic                dout;
    logic [6:0]          bit_cnt;
    logic [6:0]          total;
    logic [6:0]          n_out;
    logic [6:0]          rx_from;
    logic [63:0]         out_sh;
    logic [31:0]         rx_sh;
    logic [2:0]          pipe;
    logic [1:0]          gap;
    logic [31:0]         rdata;
  } link_s;

  core_s c;
  core_s next_c;
  link_s l;
  link_s next_l;

  logic rst_l_n;
  logic ce_l;
  logic done_l;
  logic din_l;
  logic req_l;
  logic ack_c;
  logic frame_idle;

  // crossings into the link domain
  bit_sync u_sync_rst (
    .i_clk (I_LINK_CLK),
    .i_d   (I_RST_N),
    .o_q   (rst_l_n)
  );

  bit_sync u_sync_ce (
    .i_clk (I_LINK_CLK),
    .i_d   (I_CE),
    .o_q   (ce_l)
  );

  bit_sync u_sync_done (
    .i_clk (I_LINK_CLK),
    .i_d   (I_STARTUP_DONE),
    .o_q   (done_l)
  );

  bit_sync u_sync_din (
    .i_clk (I_LINK_CLK),
    .i_d   (I_FLASH_SERIAL_IN),
    .o_q   (din_l)
  );

  bit_sync u_sync_req (
    .i_clk (I_LINK_CLK),
    .i_d   (c.req_tgl),
    .o_q   (req_l)
  );

  // crossing back into the core domain
  bit_sync u_sync_ack (
    .i_clk (I_CORE_CLK),
    .i_d   (l.ack_tgl),
    .o_q   (ack_c)
  );

  // loads the frame engine; select drops here, giving the falling edge
  function automatic link_s start_frame(
    input link_s       s,
    input logic [63:0] sh,
    input logic [6:0]  nout,
    input logic [6:0]  ndum,
    input logic [6:0]  nin
  );
    link_s r;
    r         = s;
    r.frame   = 1'b1;
    r.sel_n   = 1'b0;
    r.ph      = 1'b0;
    r.bit_cnt = 7'h00;
    r.n_out   = nout;
    r.rx_from = 7'(nout + ndum);
    r.total   = 7'(nout + ndum + nin);
    r.out_sh  = sh;
    r.dout    = (nout != 7'h00) ? sh[63] : `SF_DATA_OUT_RESET;
    return r;
  endfunction

  // core domain: accept one request, wait for the link to finish
  always_comb begin
    next_c     = c;
    next_c.rsp = 1'b0;
    if (!c.busy && I_REQ_VALID) begin
      next_c.busy    = 1'b1;
      next_c.req_tgl = ~c.req_tgl;
      next_c.addr    = I_REQ_ADDR[24:0];
      next_c.wdata   = I_REQ_WDATA;
      if (I_REQ_WRITE && I_REQ_ADDR[`SF_ERASE_BIT]) begin
        next_c.op = spi_flash_pkg::OP_ERASE;
      end else if (I_REQ_WRITE) begin
        next_c.op = spi_flash_pkg::OP_PROGRAM;
      end else begin
        next_c.op = spi_flash_pkg::OP_READ;
      end
    end else if (c.busy && (ack_c != c.ack_seen)) begin
      next_c.ack_seen = ack_c;
      next_c.busy     = 1'b0;
      next_c.rsp      = 1'b1;
      // link holds its word stable until the next request
      next_c.rdata    = l.rdata;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      c <= '0;
    end else if (I_CE) begin
      c <= next_c;
    end
  end

  assign frame_idle = !l.frame && (l.gap == 2'h0);

  // link domain: frame engine plus operation sequencer
  always_comb begin
    next_l      = l;
    next_l.pipe = {l.pipe[1:0], 1'b0};
    if (l.pipe[2]) begin
      // synchroniser delay is absorbed by the three stage tag pipe
      next_l.rx_sh = {l.rx_sh[30:0], din_l};
    end
    if (l.frame) begin
      if (l.bit_cnt != l.total) begin
        if (!l.ph) begin
          next_l.ph = 1'b1;
          if (l.bit_cnt >= l.rx_from) begin
            next_l.pipe[0] = 1'b1;
          end
        end else begin
          next_l.ph      = 1'b0;
          next_l.bit_cnt = l.bit_cnt + 7'h01;
          next_l.out_sh  = {l.out_sh[62:0], 1'b0};
          if (next_l.bit_cnt < l.n_out) begin
            next_l.dout = l.out_sh[62];
          end else begin
            next_l.dout = `SF_DATA_OUT_RESET;
          end
        end
      end else if (l.pipe == 3'h0) begin
        // last sample taken before select rises
        next_l.frame = 1'b0;
        next_l.sel_n = `SF_SELECT_N_RESET;
        next_l.dout  = `SF_DATA_OUT_RESET;
        next_l.gap   = `SF_GAP_CYCLES;
      end
    end else if (l.gap != 2'h0) begin
      next_l.gap = l.gap - 2'h1;
    end

    case (l.st)
      spi_flash_pkg::L_WAIT_START: begin
        if (done_l && frame_idle) begin
          // five clocks cover the three the handover needs
          next_l    = start_frame(next_l, 64'h0, 7'h00,
                                  `SF_HANDOVER_CLKS, 7'h00);
          next_l.st = spi_flash_pkg::L_HANDOVER;
        end
      end
      spi_flash_pkg::L_HANDOVER: begin
        if (frame_idle) begin
          next_l.st = spi_flash_pkg::L_IDLE;
        end
      end
      spi_flash_pkg::L_IDLE: begin
        if (req_l != l.req_seen) begin
          next_l.req_seen   = req_l;
          next_l.want_upper = c.addr[`SF_UPPER_BIT];
          if (c.addr[`SF_UPPER_BIT] != l.ext_upper) begin
            next_l    = start_frame(next_l,
                          {`SF_CMD_WRITE_ENABLE, 56'h0},
                          `SF_CMD_BITS, 7'h00, 7'h00);
            next_l.st = spi_flash_pkg::L_EXT_WREN;
          end else begin
            next_l.st = spi_flash_pkg::L_OP_START;
          end
        end
      end
      spi_flash_pkg::L_EXT_WREN: begin
        if (frame_idle) begin
          next_l    = start_frame(next_l,
                        {`SF_CMD_WR_EXT_ADDR, 7'h00, l.want_upper,
                         48'h0},
                        `SF_EXT_BITS, 7'h00, 7'h00);
          next_l.st = spi_flash_pkg::L_EXT_SET;
        end
      end
      spi_flash_pkg::L_EXT_SET: begin
        if (frame_idle) begin
          next_l.ext_upper = l.want_upper;
          next_l.st        = spi_flash_pkg::L_OP_START;
        end
      end
      spi_flash_pkg::L_OP_START: begin
        if (c.op == spi_flash_pkg::OP_READ) begin
          next_l    = start_frame(next_l,
                        {`SF_CMD_FAST_READ, c.addr[23:0], 32'h0},
                        `SF_ADDR_CMD_BITS, `SF_DUMMY_CLKS,
                        `SF_WORD_BITS);
          next_l.st = spi_flash_pkg::L_READ;
        end else begin
          next_l    = start_frame(next_l,
                        {`SF_CMD_WRITE_ENABLE, 56'h0},
                        `SF_CMD_BITS, 7'h00, 7'h00);
          next_l.st = spi_flash_pkg::L_OP_WREN;
        end
      end
      spi_flash_pkg::L_OP_WREN: begin
        if (frame_idle) begin
          if (c.op == spi_flash_pkg::OP_ERASE) begin
            next_l = start_frame(next_l,
                       {`SF_CMD_SECTOR_ERASE, c.addr[23:0], 32'h0},
                       `SF_ADDR_CMD_BITS, 7'h00, 7'h00);
          end else begin
            next_l = start_frame(next_l,
                       {`SF_CMD_PAGE_PROGRAM, c.addr[23:0], c.wdata},
                       `SF_PROG_BITS, 7'h00, 7'h00);
          end
          next_l.st = spi_flash_pkg::L_POLL;
        end
      end
      spi_flash_pkg::L_POLL: begin
        if (frame_idle) begin
          next_l    = start_frame(next_l,
                        {`SF_CMD_READ_STATUS, 56'h0},
                        `SF_CMD_BITS, 7'h00, `SF_STATUS_BITS);
          next_l.st = spi_flash_pkg::L_POLL_CHECK;
        end
      end
      spi_flash_pkg::L_POLL_CHECK: begin
        if (frame_idle) begin
          // keeps the bus stalled until the array is written
          if (l.rx_sh[`SF_WIP_BIT]) begin
            next_l.st = spi_flash_pkg::L_POLL;
          end else begin
            next_l.st = spi_flash_pkg::L_DONE;
          end
        end
      end
      spi_flash_pkg::L_READ: begin
        if (frame_idle) begin
          next_l.rdata = l.rx_sh;
          next_l.st    = spi_flash_pkg::L_DONE;
        end
      end
      spi_flash_pkg::L_DONE: begin
        next_l.ack_tgl = ~l.ack_tgl;
        next_l.st      = spi_flash_pkg::L_IDLE;
      end
      default: begin
        next_l.st = spi_flash_pkg::L_WAIT_START;
      end
    endcase
  end

  always_ff @(posedge I_LINK_CLK) begin
    if (!rst_l_n) begin
      l       <= '0;
      l.sel_n <= `SF_SELECT_N_RESET;
    end else if (ce_l) begin
      l <= next_l;
    end
  end

  // handshake outputs
  assign O_REQ_READY = !c.busy && I_CE;
  assign O_RSP_VALID = c.rsp;
  assign O_RSP_RDATA = c.rdata;

  // flash pins: clock, select and data out from link registers, write protect and hold tied high
  assign O_FLASH_CLOCK_PIN       = l.ph;
  assign O_FLASH_SELECT_N        = l.sel_n;
  assign O_FLASH_SERIAL_OUT      = l.dout;
  assign O_FLASH_WRITE_PROTECT_N = `SF_STRAP_HIGH;
  assign O_FLASH_PAUSE_N         = `SF_STRAP_HIGH;

endmodule

`default_nettype wire

// >>> tb/spi_flash_startup_ctrl_chk.sv
// port assertions for the flash startup controller
`timescale 1ns/1ps
`default_nettype none

module spi_flash_startup_ctrl_chk (
  // clocks and reset
  input  wire logic I_CORE_CLK,
  input  wire logic I_LINK_CLK,
  input  wire logic I_RST_N,
  // request side
  input  wire logic I_CE,
  input  wire logic I_REQ_VALID,
  input  wire logic O_REQ_READY,
  input  wire logic O_RSP_VALID,
  // flash side
  input  wire logic I_STARTUP_DONE,
  input  wire logic O_FLASH_CLOCK_PIN,
  input  wire logic O_FLASH_SELECT_N,
  input  wire logic O_FLASH_SERIAL_OUT,
  input  wire logic O_FLASH_WRITE_PROTECT_N,
  input  wire logic O_FLASH_PAUSE_N
);
  a_wp_high: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    O_FLASH_WRITE_PROTECT_N) else $error("write protect low");
  a_hold_high: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    O_FLASH_PAUSE_N) else $error("hold line low");
  a_take_busy: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    I_REQ_VALID && O_REQ_READY |=> !O_REQ_READY) else $error("second take");
  a_rsp_pulse: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    O_RSP_VALID |=> !O_RSP_VALID) else $error("answer longer than one");
  a_rsp_ready: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    O_RSP_VALID && I_CE |-> O_REQ_READY) else $error("not ready at answer");
  a_sel_reset: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $rose(I_RST_N) |-> O_FLASH_SELECT_N && !O_FLASH_CLOCK_PIN)
    else $error("select low at reset exit");
  a_clk_sel: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
    O_FLASH_CLOCK_PIN |-> !O_FLASH_SELECT_N) else $error("clock while idle");
  a_clk_half: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
    $rose(O_FLASH_CLOCK_PIN) |=> $fell(O_FLASH_CLOCK_PIN))
    else $error("serial clock high too long");
  a_dout_idle: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
    O_FLASH_SELECT_N |-> !O_FLASH_SERIAL_OUT) else $error("data out idle high");
  a_no_early: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
    $rose(O_FLASH_CLOCK_PIN) |-> $past(I_STARTUP_DONE, 3))
    else $error("clock before startup done");
  a_sel_gap: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
    $rose(O_FLASH_SELECT_N) |=> O_FLASH_SELECT_N [*2]) else $error("short gap");
  c_answer: cover property (@(posedge I_CORE_CLK) O_RSP_VALID);
  c_frame: cover property (@(posedge I_LINK_CLK) $rose(O_FLASH_SELECT_N));
  c_frozen: cover property (@(posedge I_CORE_CLK) I_REQ_VALID && !I_CE);
endmodule

`default_nettype wire

// >>> tb/flash_model.sv
// behavioural serial flash at the far end of the link
`timescale 1ns/1ps
`default_nettype none

module flash_model (
  // link pins
  input  wire logic i_sck,
  input  wire logic i_sel_n,
  input  wire logic i_mosi,
  output logic      o_miso
);
  logic [63:0] sh;
  logic [7:0]  op;
  logic [23:0] addr;
  logic [31:0] rd;
  logic [31:0] pw;
  logic        ext;
  logic        armed;
  int          nb;
  int          polls;
  logic [15:0] frames[$];

  initial begin
    {ext, armed, o_miso} = 3'h0;
    op = 8'h00;
    nb = 0;
    polls = 0;
  end
  // no command counts before the first select fall
  always @(negedge i_sel_n) begin
    nb = 0;
    op = 8'h00;
    armed = 1'b1;
  end
  always @(posedge i_sck) if (armed) begin
    sh = {sh[62:0], i_mosi};
    nb = nb + 1;
    if (nb == 8) op = sh[7:0];
    if (nb == 32) addr = sh[23:0];
    rd = {7'h2a, ext, addr};
  end
  // busy for two status polls after each program or erase
  always @(posedge i_sel_n) if (armed) begin
    frames.push_back({nb[7:0], op});
    if (op == 8'hc5 && nb == 16) ext = sh[0];
    if (op == 8'h05) polls = polls + 1;
    if (op == 8'h02 || op == 8'hd8) polls = 0;
    if (op == 8'h02) pw = sh[31:0];
  end
  always @(negedge i_sck or posedge i_sel_n)
    if (!i_sel_n && op == 8'h0b && nb >= 40 && nb < 72)
      o_miso <= rd[71-nb];
    else if (!i_sel_n && op == 8'h05 && nb >= 8)
      o_miso <= (nb == 15) && (polls < 2);
    else
      o_miso <= ~o_miso;
endmodule

`default_nettype wire

// >>> tb/spi_flash_startup_ctrl_test.sv
// self-checking bench for the flash startup controller
`timescale 1ns/1ps
`default_nettype none

module spi_flash_startup_ctrl_test;
  typedef struct {
    logic        w;
    logic [25:0] a;
    logic [31:0] d;
    logic [31:0] q;
    int          n;
    logic [63:0] ops;
  } row_s;

  logic        clk, lclk, rst_n, ce, vld, wr, done, miso;
  logic        ready, rsp, sck, sel_n, mosi, wp_n, hold_n;
  logic [25:0] addr;
  logic [31:0] wdata, rdata;
  int          err_count, n_compared;
  // ops are listed first frame in the low byte
  row_s        rows[6] = '{
    '{1'b0, 26'h0000100, 32'h0, 32'h54000100, 2, 64'h0b00},
    '{1'b0, 26'h1000010, 32'h0, 32'h55000010, 3, 64'h0bc506},
    '{1'b1, 26'h1000020, 32'h12345678, 32'h12345678, 5, 64'h0505050206},
    '{1'b1, 26'h2000040, 32'h0, 32'h12345678, 7, 64'h050505d806c506},
    '{1'b0, 26'h0fffffc, 32'h0, 32'h54fffffc, 1, 64'h0b},
    '{1'b0, 26'h2000008, 32'h0, 32'h54000008, 1, 64'h0b}};

  spi_flash_startup_ctrl dut_u (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_LINK_CLK(lclk),
    .I_REQ_VALID(vld), .I_REQ_WRITE(wr), .I_REQ_ADDR(addr),
    .I_REQ_WDATA(wdata), .O_REQ_READY(ready), .O_RSP_VALID(rsp),
    .O_RSP_RDATA(rdata), .I_STARTUP_DONE(done), .O_FLASH_CLOCK_PIN(sck),
    .O_FLASH_SELECT_N(sel_n), .O_FLASH_SERIAL_OUT(mosi),
    .I_FLASH_SERIAL_IN(miso), .O_FLASH_WRITE_PROTECT_N(wp_n),
    .O_FLASH_PAUSE_N(hold_n));
  flash_model fl_u (.i_sck(sck), .i_sel_n(sel_n), .i_mosi(mosi),
    .o_miso(miso));

  function automatic logic [7:0] flen(input logic [7:0] op);
    case (op)
      8'h00: flen = 8'h05;
      8'h06: flen = 8'h08;
      8'h0b: flen = 8'h48;
      8'h02: flen = 8'h40;
      8'h05, 8'hc5: flen = 8'h10;
      default: flen = 8'h20;
    endcase
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic run(input row_s r);
    int base;
    int t;
    base = fl_u.frames.size();
    @(posedge clk);
    {wr, addr, wdata} <= {r.w, r.a, r.d};
    vld <= 1'b1;
    @(negedge clk);
    for (t = 0; t < 9000 && ready !== 1'b1; t++) @(negedge clk);
    @(posedge clk);
    vld <= 1'b0;
    for (t = 0; t < 9000 && rsp !== 1'b1; t++) @(negedge clk);
    chk(64'(rsp), 64'h1);
    chk(r.w ? fl_u.pw : rdata, r.q);
    chk(64'(fl_u.addr), 64'(r.a[23:0]));
    chk(64'(fl_u.frames.size()), 64'(base + r.n));
    for (int i = 0; i < r.n; i++)
      chk(fl_u.frames[base+i], {flen(r.ops[8*i+:8]), r.ops[8*i+:8]});
  endtask

  task automatic stop_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // link clock offset so its edges never line up with the core clock
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #7.5 lclk = ~lclk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    {rst_n, ce, vld, wr, done} = 5'h08;
    addr = 26'h0;
    wdata = 32'h0;
    err_count = 0;
    n_compared = 0;
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk(64'({sel_n, sck, mosi, rsp, wp_n, hold_n}), 64'h23);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (60) @(posedge clk);
    chk(64'(fl_u.frames.size()), 64'h0);
    done <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    // a request held while frozen must not start
    @(posedge clk);
    ce <= 1'b0;
    vld <= 1'b1;
    repeat (10) @(negedge clk);
    chk(64'({ready, rsp}), 64'h0);
    @(posedge clk);
    ce <= 1'b1;
    vld <= 1'b0;
    @(negedge clk);
    chk(64'(ready), 64'h1);
    // leave the upper half selected before the second reset
    run(rows[1]);
    // second reset repeats the burst and drops back to the lower half
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk(64'({sel_n, sck, mosi, rsp, ready}), 64'h11);
    @(posedge clk);
    rst_n <= 1'b1;
    run('{1'b0, 26'h1000000, 32'h0, 32'h55000000, 4, 64'h0bc50600});
    stop_test();
  end
endmodule

bind spi_flash_startup_ctrl spi_flash_startup_ctrl_chk chk_u (
  .I_CORE_CLK(I_CORE_CLK), .I_LINK_CLK(I_LINK_CLK), .I_RST_N(I_RST_N),
  .I_CE(I_CE), .I_REQ_VALID(I_REQ_VALID), .O_REQ_READY(O_REQ_READY),
  .O_RSP_VALID(O_RSP_VALID), .I_STARTUP_DONE(I_STARTUP_DONE),
  .O_FLASH_CLOCK_PIN(O_FLASH_CLOCK_PIN), .O_FLASH_SELECT_N(O_FLASH_SELECT_N),
  .O_FLASH_SERIAL_OUT(O_FLASH_SERIAL_OUT),
  .O_FLASH_WRITE_PROTECT_N(O_FLASH_WRITE_PROTECT_N),
  .O_FLASH_PAUSE_N(O_FLASH_PAUSE_N));

`default_nettype wire
